// file: rtl/bdt_addr_gen.sv
// start address and written-back base for one block transfer
`timescale 1ns/1ps
module bdt_addr_gen
	import bdt_pkg::*;
(
	bdt_seq_if.addr sif
);
	import bdt_pkg::*;

	logic [31:0] span;
	logic [4:0] cnt;

	// ----------------------------------------
	// register count and address span
	// ----------------------------------------
	always_comb
	begin
		cnt = 5'h00;
		for (int i = 0; i < BDT_LIST_W; i++)
			cnt = cnt + {4'h0, sif.list[i]};
		span = {25'h0, cnt, 2'h0};
	end

	// ----------------------------------------
	// four stacking modes; low two base bits ride along untouched
	// ----------------------------------------
	always_comb
	begin
		if (sif.up)
		begin
			sif.start_addr = sif.pre ? sif.base + BDT_WORD_STEP : sif.base;
			sif.new_base = sif.base + span;
		end
		else
		begin
			// lowest register still lands at the lowest address
			sif.start_addr = sif.pre ? sif.base - span
				: sif.base - span + BDT_WORD_STEP;
			sif.new_base = sif.base - span;
		end
	end
endmodule : bdt_addr_gen

// file: rtl/bdt_pkg.sv
// constants and types for the block data transfer engine
package bdt_pkg;
	// ----------------------------------------
	// instruction fields
	// ----------------------------------------
	localparam int BDT_P_BIT = 24;
	localparam int BDT_U_BIT = 23;
	localparam int BDT_S_BIT = 22;
	localparam int BDT_W_BIT = 21;
	localparam int BDT_L_BIT = 20;
	localparam int BDT_BASE_LSB = 16;
	localparam int BDT_LIST_W = 16;
	localparam logic [3:0] BDT_PC_IDX = 4'hf;
	// ----------------------------------------
	// address arithmetic
	// ----------------------------------------
	localparam logic [31:0] BDT_WORD_STEP = 32'h0000_0004;
	localparam logic [31:0] BDT_PC_STORE_OFS = 32'h0000_000c;
	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [4:0] {
		BDT_IDLE = 5'b00001,
		BDT_SETUP = 5'b00010,
		BDT_XFER = 5'b00100,
		BDT_TAIL = 5'b01000,
		BDT_END = 5'b10000
	} bdt_state_t;
endpackage : bdt_pkg

// file: rtl/bdt_reg_pick.sv
// lowest remaining register of the list
`timescale 1ns/1ps
module bdt_reg_pick
	import bdt_pkg::*;
(
	bdt_seq_if.pick sif
);
	import bdt_pkg::*;

	always_comb
	begin
		sif.pick_idx = 4'h0;
		for (int i = BDT_LIST_W - 1; i >= 0; i--)
			if (sif.remain[i])
				sif.pick_idx = 4'(i);
		sif.next_remain = sif.remain & (sif.remain - 16'h0001);
		sif.last = (sif.next_remain == 16'h0000);
	end
endmodule : bdt_reg_pick

// file: rtl/bdt_seq_if.sv
// carrier between the sequencer and its address and register pickers
`timescale 1ns/1ps
interface bdt_seq_if;
	logic [31:0] base;
	logic [15:0] list;
	logic pre;
	logic up;
	logic [31:0] start_addr;
	logic [31:0] new_base;
	logic [15:0] remain;
	logic [3:0] pick_idx;
	logic [15:0] next_remain;
	logic last;
	modport addr (input base, list, pre, up, output start_addr, new_base);
	modport pick (input remain, output pick_idx, next_remain, last);
	modport ctl (output base, list, pre, up, remain,
		input start_addr, new_base, pick_idx, next_remain, last);
endinterface : bdt_seq_if

// file: rtl/block_data_transfer.sv
// load-multiple and store-multiple execution sequencer
`timescale 1ns/1ps
// Summary of operation
// - failed condition leaves everything untouched
// - list bit n selects register n
// - stored program counter is instruction plus twelve
// - ascending order, lowest register lowest address
// - base, before/after, direction form addresses
// - no write-back keeps base unless loaded
// - low address bits ignored but driven
// - load with pc and flag restores status
// - store with pc and flag uses user bank
// - flag without pc uses user bank
// - base written back end of second cycle
// - loaded base value beats written-back base
// - store abort runs on, then traps
// - load abort stops register updates, pc kept
// - aborted load restores base register
// - trap only after aborted load finishes
module block_data_transfer
	import bdt_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic cond_pass,
	input wire logic [31:0] instr_addr,
	output logic busy,
	output logic done,
	output logic abort_trap,
	output logic status_restore,
	output logic [3:0] reg_rd_idx,
	output logic reg_rd_user,
	input wire logic [31:0] reg_rd_data,
	output logic reg_wr_en,
	output logic [3:0] reg_wr_idx,
	output logic reg_wr_user,
	output logic [31:0] reg_wr_data,
	output logic mem_req,
	output logic mem_rd,
	output logic mem_write,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_abort
);
	import bdt_pkg::*;

	bdt_state_t state_q, state_d;
	logic [31:0] instr_q, instr_d;
	logic [31:0] pc_q, pc_d;
	logic [31:0] base_q, base_d;
	logic [31:0] addr_q, addr_d;
	logic [31:0] wb_base_q, wb_base_d;
	logic [15:0] remain_q, remain_d;
	logic first_q, first_d;
	logic abort_q, abort_d;
	logic ldv_q, ldv_d;
	logic [3:0] ldidx_q, ldidx_d;
	logic [31:0] lddata_q, lddata_d;
	logic is_load, wb_on, s_on, user_bank, pc_listed;
	logic [3:0] base_idx;

	bdt_seq_if sif ();

	bdt_addr_gen u_addr (
		.sif(sif)
	);

	bdt_reg_pick u_pick (
		.sif(sif)
	);

	// ----------------------------------------
	// instruction decode
	// ----------------------------------------
	assign is_load = instr_q[BDT_L_BIT];
	assign wb_on = instr_q[BDT_W_BIT];
	assign s_on = instr_q[BDT_S_BIT];
	assign base_idx = instr_q[BDT_BASE_LSB +: 4];
	assign pc_listed = instr_q[BDT_PC_IDX];
	// pc with a load means status restore, never user bank
	assign user_bank = s_on & ~(is_load & pc_listed);

	assign sif.base = reg_rd_data;
	assign sif.list = instr_q[BDT_LIST_W-1:0];
	assign sif.pre = instr_q[BDT_P_BIT];
	assign sif.up = instr_q[BDT_U_BIT];
	assign sif.remain = remain_q;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb
	begin
		state_d = state_q;
		instr_d = instr_q;
		pc_d = pc_q;
		base_d = base_q;
		addr_d = addr_q;
		wb_base_d = wb_base_q;
		remain_d = remain_q;
		first_d = first_q;
		abort_d = abort_q;
		ldv_d = 1'b0;
		ldidx_d = ldidx_q;
		lddata_d = lddata_q;
		case (state_q)
			BDT_IDLE:
			begin
				if (instr_valid && cond_pass)
				begin
					instr_d = instr_word;
					pc_d = instr_addr;
					abort_d = 1'b0;
					state_d = BDT_SETUP;
				end
			end
			BDT_SETUP:
			begin
				base_d = reg_rd_data;
				addr_d = sif.start_addr;
				wb_base_d = sif.new_base;
				remain_d = sif.list;
				first_d = 1'b1;
				// an empty list moves no register and skips the transfer loop, going straight to BDT_END
				state_d = (sif.list == 16'h0000) ? BDT_END : BDT_XFER;
			end
			BDT_XFER:
			begin
				first_d = 1'b0;
				addr_d = addr_q + BDT_WORD_STEP;
				remain_d = sif.next_remain;
				if (mem_abort)
					abort_d = 1'b1;
				// the aborting load and everything after it is dropped
				if (is_load && !mem_abort && !abort_q)
				begin
					ldv_d = 1'b1;
					ldidx_d = sif.pick_idx;
					lddata_d = mem_rdata;
				end
				if (sif.last)
					state_d = BDT_TAIL;
			end
			BDT_TAIL:
				state_d = BDT_END;
			BDT_END:
				state_d = BDT_IDLE;
			default:
				state_d = BDT_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q <= BDT_IDLE;
			instr_q <= 32'h0000_0000;
			pc_q <= 32'h0000_0000;
			base_q <= 32'h0000_0000;
			addr_q <= 32'h0000_0000;
			wb_base_q <= 32'h0000_0000;
			remain_q <= 16'h0000;
			first_q <= 1'b0;
			abort_q <= 1'b0;
			ldv_q <= 1'b0;
			ldidx_q <= 4'h0;
			lddata_q <= 32'h0000_0000;
		end
		else
		begin
			state_q <= state_d;
			instr_q <= instr_d;
			pc_q <= pc_d;
			base_q <= base_d;
			addr_q <= addr_d;
			wb_base_q <= wb_base_d;
			remain_q <= remain_d;
			first_q <= first_d;
			abort_q <= abort_d;
			ldv_q <= ldv_d;
			ldidx_q <= ldidx_d;
			lddata_q <= lddata_d;
		end
	end

	// ----------------------------------------
	// memory side
	// ----------------------------------------
	assign mem_req = (state_q == BDT_XFER);
	assign mem_rd = mem_req & is_load;
	assign mem_write = mem_req & ~is_load;
	// low bits of the base pass straight through the word steps
	assign mem_addr = addr_q;
	assign mem_wdata = (sif.pick_idx == BDT_PC_IDX) ? pc_q + BDT_PC_STORE_OFS
		: reg_rd_data;

	// ----------------------------------------
	// register file side
	// ----------------------------------------
	always_comb
	begin
		reg_rd_idx = (state_q == BDT_XFER) ? sif.pick_idx : base_idx;
		reg_rd_user = (state_q == BDT_XFER) & ~is_load & user_bank;
		reg_wr_en = 1'b0;
		reg_wr_idx = base_idx;
		reg_wr_user = 1'b0;
		reg_wr_data = wb_base_q;
		if (state_q == BDT_XFER && first_q && wb_on)
			// store of the base as first register still reads the old value
			reg_wr_en = 1'b1;
		else if (ldv_q)
		begin
			// delayed one cycle so a loaded base lands after write-back
			reg_wr_en = 1'b1;
			reg_wr_idx = ldidx_q;
			reg_wr_user = user_bank;
			reg_wr_data = lddata_q;
		end
		else if (state_q == BDT_END && is_load && abort_q)
		begin
			reg_wr_en = 1'b1;
			reg_wr_data = wb_on ? wb_base_q : base_q;
		end
	end

	assign busy = (state_q != BDT_IDLE);
	assign done = (state_q == BDT_END);
	assign abort_trap = (state_q == BDT_END) & abort_q;
	assign status_restore = ldv_q & (ldidx_q == BDT_PC_IDX) & s_on;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	cond_skip_a: assert property (state_q == BDT_IDLE && instr_valid && !cond_pass
		|=> state_q == BDT_IDLE) else $error("failed condition started");
	busy_gate_a: assert property (state_q == BDT_IDLE && instr_valid && cond_pass
		|=> state_q == BDT_SETUP) else $error("passed condition not taken");
	no_touch_a: assert property (!busy |-> !mem_req && !reg_wr_en)
		else $error("activity while idle");
	list_pick_a: assert property (mem_req |-> instr_q[sif.pick_idx])
		else $error("unlisted register moved");
	xfer_order_a: assert property (mem_req && !sif.last
		|=> mem_req && sif.pick_idx > $past(sif.pick_idx)) else $error("order wrong");
	pc_store_a: assert property (mem_write && sif.pick_idx == BDT_PC_IDX
		|-> mem_wdata == pc_q + BDT_PC_STORE_OFS) else $error("stored pc wrong");
	addr_step_a: assert property (mem_req && !sif.last
		|=> mem_addr == $past(mem_addr) + BDT_WORD_STEP) else $error("step wrong");
	up_start_a: assert property (mem_req && first_q && sif.up
		|-> mem_addr == base_q + (sif.pre ? BDT_WORD_STEP : 32'h0000_0000))
		else $error("ascending start wrong");
	down_end_a: assert property (mem_req && sif.last && !sif.up
		|-> mem_addr == base_q - (sif.pre ? BDT_WORD_STEP : 32'h0000_0000))
		else $error("descending end wrong");
	read_sel_a: assert property (mem_req |-> mem_rd == is_load && mem_write != is_load)
		else $error("read select wrong");
	low_bits_a: assert property (mem_req |-> mem_addr[1:0] == base_q[1:0])
		else $error("low bits changed");
	base_wb_a: assert property (state_q == BDT_SETUP && instr_q[BDT_W_BIT]
		&& sif.list != 16'h0000 |=> reg_wr_en && reg_wr_idx == base_idx
		&& reg_wr_data == wb_base_q) else $error("write-back missing");
	wb_bank_a: assert property (reg_wr_en && reg_wr_idx == base_idx && !ldv_q
		|-> !reg_wr_user) else $error("base written in user bank");
	no_wb_a: assert property (busy && !wb_on && !is_load |-> !reg_wr_en)
		else $error("base changed without write-back");
	store_bank_a: assert property (mem_write |-> reg_rd_user == s_on)
		else $error("store bank wrong");
	load_bank_a: assert property (reg_wr_en && ldv_q
		|-> reg_wr_user == (s_on && !pc_listed)) else $error("load bank wrong");
	load_write_a: assert property (mem_rd && !mem_abort && !abort_q
		|=> reg_wr_en && reg_wr_idx == $past(sif.pick_idx)
		&& reg_wr_data == $past(mem_rdata)) else $error("loaded word lost");
	load_stop_a: assert property (mem_rd && (mem_abort || abort_q) |=> !reg_wr_en)
		else $error("register written after abort");
	pc_kept_a: assert property (reg_wr_en && reg_wr_idx == BDT_PC_IDX && busy
		&& state_q != BDT_END |-> !abort_q) else $error("pc written after abort");
	base_restore_a: assert property (state_q == BDT_END && is_load && abort_q
		|-> reg_wr_en && reg_wr_idx == base_idx && !reg_wr_user)
		else $error("base not restored");
	store_trap_a: assert property (mem_write && mem_abort && !sif.last
		|=> mem_write) else $error("store stopped on abort");
	trap_late_a: assert property (mem_req && mem_abort
		|-> !abort_trap ##[1:17] abort_trap) else $error("trap timing wrong");
	restore_a: assert property (status_restore
		|-> reg_wr_en && reg_wr_idx == BDT_PC_IDX && !reg_wr_user) else $error("status restore");
	status_only_a: assert property (status_restore |-> is_load && !abort_q)
		else $error("status restored after abort");

	store_run_c: cover property (mem_write && sif.pick_idx == BDT_PC_IDX);
	load_abort_c: cover property (mem_rd && mem_abort ##[1:17] abort_trap);
	store_abort_c: cover property (mem_write && mem_abort ##[1:17] abort_trap);
	user_load_c: cover property (reg_wr_en && reg_wr_user);
	status_copy_c: cover property (status_restore);
endmodule : block_data_transfer

// file: verification/bdt_mem_model.sv
// memory system and memory manager model for the block transfer bench
`timescale 1ns/1ps
module bdt_mem_model (
	input wire logic clk,
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic abort_en,
	input wire logic [31:0] abort_addr,
	output logic [31:0] mem_rdata,
	output logic mem_abort
);
	logic [31:0] mem [0:63];
	logic [31:0] idle_q = 32'h0;
	initial
	begin
		for (int i = 0; i < 64; i++) mem[i] = 32'h5a00_0000 + 32'(i);
	end
	// flagged in the same cycle as the offending transfer
	assign mem_abort = mem_req && abort_en && (mem_addr == abort_addr);
	// bus outside a transfer carries a moving pattern, never stale data
	assign mem_rdata = mem_req ? mem[mem_addr[7:2]] : idle_q;
	always @(posedge clk)
	begin
		idle_q <= ~idle_q ^ 32'h1;
		if (mem_req && mem_write && !mem_abort) mem[mem_addr[7:2]] <= mem_wdata;
	end
endmodule : bdt_mem_model

// file: verification/testbench.sv
// self-checking bench for the block data transfer engine
`timescale 1ns/1ps
module testbench;
	import bdt_pkg::*;
	typedef struct {logic p, u, s, w, l, c; logic [3:0] b; logic [15:0] lst; int ab, cyc;} bdt_row_t;
	logic clk, sys_rst, instr_valid, cond_pass, abort_en, busy, done, abort_trap, status_restore;
	logic reg_rd_user, reg_wr_en, reg_wr_user, mem_req, mem_rd, mem_write, mem_abort;
	logic [3:0] reg_rd_idx, reg_wr_idx;
	logic [31:0] instr_word, instr_addr, abort_addr, mem_rdata, reg_rd_data;
	logic [31:0] mem_addr, mem_wdata, reg_wr_data;
	logic [31:0] rf [0:1][0:15];
	logic [31:0] em [0:63];
	int n_errors, check_count;
	// --------------------------------------------
	// cases: p u s w l cond base list abort done
	// --------------------------------------------
	// lists never empty, pc never base, no write-back with s
	bdt_row_t rows [14] = '{
		'{0,1,0,1,0,1,4'h2,16'h0022,-1,5}, '{1,1,0,1,0,1,4'h2,16'h800c,-1,6},
		'{1,0,0,1,0,1,4'h2,16'h0006,-1,5}, '{0,0,0,0,0,1,4'h4,16'h0091,-1,6},
		'{0,1,0,1,1,1,4'h2,16'h000c,-1,5}, '{1,1,1,0,1,1,4'h3,16'h8003,-1,6},
		'{1,0,1,0,1,1,4'h5,16'h0140,-1,5}, '{0,0,1,0,0,1,4'h6,16'h0201,-1,5},
		'{0,1,0,1,0,0,4'h2,16'h0002,-1,0}, '{0,1,0,1,1,1,4'h2,16'h800e,2,7},
		'{0,1,0,1,0,1,4'h2,16'h0007,1,6}, '{0,1,0,0,0,1,4'h1,16'hffff,-1,19},
		'{0,1,1,0,1,1,4'h3,16'h8000,0,4}, '{1,1,0,0,0,1,4'h7,16'h0002,-1,4}};
	block_data_transfer block_data_transfer_i (.clk(clk), .sys_rst(sys_rst),
		.instr_valid(instr_valid), .instr_word(instr_word), .cond_pass(cond_pass),
		.instr_addr(instr_addr), .busy(busy), .done(done), .abort_trap(abort_trap),
		.status_restore(status_restore), .reg_rd_idx(reg_rd_idx), .reg_rd_user(reg_rd_user),
		.reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en), .reg_wr_idx(reg_wr_idx),
		.reg_wr_user(reg_wr_user), .reg_wr_data(reg_wr_data), .mem_req(mem_req),
		.mem_rd(mem_rd), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_abort(mem_abort));
	bdt_mem_model bdt_mem_model_i (.clk(clk), .mem_req(mem_req), .mem_write(mem_write),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .abort_en(abort_en),
		.abort_addr(abort_addr), .mem_rdata(mem_rdata), .mem_abort(mem_abort));
	// register file: two banks, read the same cycle
	assign reg_rd_data = rf[reg_rd_user][reg_rd_idx];
	always @(posedge clk)
	begin
		if (reg_wr_en) rf[reg_wr_user][reg_wr_idx] <= reg_wr_data;
	end
	always #2 clk = ~clk;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want)
		begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, want, seen);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	task automatic run(input bdt_row_t r);
		logic [31:0] base, nb, st, a, d;
		logic [31:0] ex [0:1][0:15];
		logic [31:0] o [0:1][0:15];
		logic ub;
		int n, k, ri, tdone, nsr;
		ub = r.s && !(r.l && r.lst[15]);
		n = $countones(r.lst);
		o = rf;
		ex = rf;
		base = rf[0][r.b];
		nb = r.u ? base + 32'(4 * n) : base - 32'(4 * n);
		st = r.u ? (r.p ? base + BDT_WORD_STEP : base) : (r.p ? nb : nb + BDT_WORD_STEP);
		if (r.c && r.w) ex[0][r.b] = nb;
		k = 0;
		ri = 0;
		tdone = 0;
		nsr = 0;
		@(negedge clk);
		abort_en = (r.ab >= 0);
		abort_addr = st + 32'(4 * r.ab);
		instr_word = {4'he, 3'b100, r.p, r.u, r.s, r.w, r.l, r.b, r.lst};
		cond_pass = r.c;
		instr_valid = 1'b1;
		for (int cyc = 1; cyc < 40 && tdone == 0; cyc++)
		begin
			@(negedge clk);
			instr_valid = 1'b0;
			check("busy", 32'(busy), 32'(r.c));
			if (mem_req)
			begin
				while (ri < 15 && !r.lst[ri]) ri++;
				a = st + 32'(4 * k);
				d = (ri == 15) ? instr_addr + BDT_PC_STORE_OFS : o[ub][ri];
				if (ri == r.b && k > 0 && r.w) d = nb;
				check("mem_addr", mem_addr, a);
				check("mem_rd", 32'(mem_rd), 32'(r.l));
				check("mem_write", 32'(mem_write), 32'(!r.l));
				if (!r.l) check("mem_wdata", mem_wdata, d);
				if (!r.l && k != r.ab) em[a[7:2]] = d;
				if (r.l && (r.ab < 0 || k < r.ab)) ex[ub][ri] = em[a[7:2]];
				k++;
				ri++;
			end
			if (status_restore) nsr++;
			if (done)
			begin
				tdone = cyc;
				check("abort_trap", 32'(abort_trap), 32'(r.ab >= 0));
			end
		end
		if (r.l && r.ab >= 0) ex[0][r.b] = r.w ? nb : o[0][r.b];
		check("done cycle", 32'(tdone), 32'(r.cyc));
		check("transfers", 32'(k), 32'(r.c ? n : 0));
		check("status_restore", 32'(nsr), 32'(r.l && r.s && r.lst[15] && r.ab < 0));
		@(posedge clk);
		#1;
		check("busy after", 32'(busy), 32'h0);
		for (int i = 0; i < 32; i++)
			check("register", rf[i/16][i%16], ex[i/16][i%16]);
		if (tdone == 0 && r.cyc != 0) close_out();
	endtask : run
	initial
	begin
		clk = 1'b0;
		sys_rst = 1'b1;
		instr_valid = 1'b0;
		instr_word = 32'h0;
		cond_pass = 1'b0;
		instr_addr = 32'h0000_0800;
		abort_en = 1'b0;
		abort_addr = 32'h0;
		n_errors = 0;
		check_count = 0;
		for (int i = 0; i < 32; i++) rf[i/16][i%16] = 32'h100 + 32'(i * 16);
		for (int i = 0; i < 64; i++) em[i] = 32'h5a00_0000 + 32'(i);
		// unaligned base: low bits must reach the bus untouched
		rf[0][7] = 32'h0000_0173;
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		foreach (rows[i])
		begin
			run(rows[i]);
			$display("test %0d done", i);
		end
		// ----------------------------------------
		// reset in mid-run
		// ----------------------------------------
		@(negedge clk);
		instr_valid = 1'b1;
		cond_pass = 1'b1;
		@(negedge clk);
		instr_valid = 1'b0;
		@(negedge clk);
		check("mem_req", 32'(mem_req), 32'h1);
		sys_rst = 1'b1;
		@(negedge clk);
		check("reset write", 32'(reg_wr_en), 32'h0);
		sys_rst = 1'b0;
		check("busy", 32'(busy), 32'h0);
		check("mem_req", 32'(mem_req), 32'h0);
		run(rows[0]);
		$display("test reset done");
		close_out();
	end
endmodule : testbench
